// [hdl/ramp_pulse_channel_one.sv]
// ramp_pulse_channel_one: table driven ramped pulse train with wishbone registers
// assumes pin inputs are asynchronous and a classic wishbone master on clk_i
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
module ramp_pulse_channel_one #(
  parameter logic [31:0] TICK_CYCLES = ramp_pkg::TICK_CYC
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // control pins
  input wire logic run_input_pin_i,
  input wire logic init_request_input_i,
  input wire logic step_interrupt_i,
  // motor side
  output logic pulse_out_a_o,
  output logic pulse_out_b_o,
  output logic direction_out_wide_o,
  output logic direction_out_narrow_o,
  // status
  output logic output_active_flag_o,
  output logic output_done_flag_o,
  output logic freq_changing_flag_o,
  output logic irq_o
);

  typedef logic [3:0][31:0] entry_t;

  typedef struct packed {
    logic run_s1;
    logic run_s2;
    logic run_d;
    logic ini_s1;
    logic ini_s2;
    logic int_s1;
    logic int_s2;
    logic int_d;
    logic ack;
    logic [31:0] rdat;
    logic [31:0] ctrl;
    logic [31:0] ctrl_run;
    logic [ramp_pkg::STEPS-1:0][3:0][31:0] tab;
    logic [ramp_pkg::STEPS-1:0][3:0][31:0] tab_run;
    logic [2:0] irq_st;
    logic [2:0] irq_en;
    ramp_pkg::fsm_t st;
    logic active;
    logic done;
    logic dir;
    logic sdir;
    logic after;
    logic [16:0] freq;
    logic [16:0] tgt;
    logic [16:0] rate;
    logic [31:0] acc;
    logic [13:0] tms;
    logic [31:0] tick_cnt;
    logic [26:0] pcnt;
    logic [26:0] preset;
    logic [4:0] step;
    logic [4:0] next;
    logic pa;
    logic pb;
    logic dout;
  } core_t;

  core_t s_reg;
  core_t s_next;
  logic nco_pulse;
  logic nco_fall;
  logic [16:0] nco_hz;

  // ==========================================================
  // helpers

  // lowest frequency of the latched mode, in mode units
  function automatic logic [16:0] min_units(input logic [31:0] c);
    min_units = c[ramp_pkg::CTRL_MODE] ? ramp_pkg::MIN_HI : ramp_pkg::MIN_LO;
  endfunction

  function automatic logic [16:0] absdiff(input logic [16:0] a, input logic [16:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  // byte lane merge for wishbone writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    merge = (o & ~m) | (d & m);
  endfunction

  // enter step n from the latched table; n out of range ends the output
  function automatic core_t load_step(input core_t s, input logic [4:0] n);
    core_t r;
    entry_t e;
    logic [16:0] mn;
    logic [16:0] f;
    r = s;
    e = '0;
    mn = min_units(s.ctrl_run);
    if (n == 5'h00 || n > 5'(ramp_pkg::STEPS)) begin
      r.active = 1'b0;
      r.done = 1'b1;
      r.st = ramp_pkg::ST_IDLE;
    end else begin
      e = s.tab_run[n - 5'h01];
      f = e[ramp_pkg::F_FREQ][16:0];
      r.tgt = (f < mn) ? mn : f;
      r.tms = (e[ramp_pkg::F_TIME][13:0] == 14'h0000) ? 14'h0001 : e[ramp_pkg::F_TIME][13:0];
      r.preset = e[ramp_pkg::F_PRESET][26:0];
      r.sdir = e[ramp_pkg::F_OPT][ramp_pkg::OPT_DIR];
      r.after = e[ramp_pkg::F_OPT][ramp_pkg::OPT_AFTER];
      r.next = e[ramp_pkg::F_OPT][ramp_pkg::OPT_NEXT_LO +: 5];
      r.step = n;
      r.pcnt = '0;
      r.acc = '0;
      if (r.sdir != s.dir) begin
        r.st = ramp_pkg::ST_TURN; // slow down before reversing
        r.rate = absdiff(s.freq, mn);
      end else begin
        r.st = ramp_pkg::ST_RUN;
        r.rate = absdiff(r.tgt, s.freq);
      end
    end
    return r;
  endfunction

  // ==========================================================
  // pulse divider, runs only while active
  assign nco_hz = s_reg.ctrl_run[ramp_pkg::CTRL_MODE] ?
                  17'(s_reg.freq * ramp_pkg::SCALE_HI) : s_reg.freq;

  pulse_nco u_nco (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(s_reg.active),
    .hz_i(nco_hz),
    .pulse_o(nco_pulse),
    .fall_o(nco_fall)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic [16:0] mn;
    logic [16:0] rt;
    logic [31:0] accn;
    logic tick;
    logic rd;
    logic wr;
    logic tab_hit;
    logic [11:0] toff;
    logic [4:0] tidx;
    logic [1:0] fld;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [1:0] rev;
    s_next = s_reg;
    mn = min_units(s_reg.ctrl_run);
    rt = s_reg.tgt;
    accn = s_reg.acc;
    ev = 3'b000;
    clr = 3'b000;
    rev = s_reg.ctrl_run[ramp_pkg::CTRL_REV_LO +: 2];

    // pin synchronisers, two stages before any use
    s_next.run_s1 = run_input_pin_i;
    s_next.run_s2 = s_reg.run_s1;
    s_next.run_d = s_reg.run_s2;
    s_next.ini_s1 = init_request_input_i;
    s_next.ini_s2 = s_reg.ini_s1;
    s_next.int_s1 = step_interrupt_i;
    s_next.int_s2 = s_reg.int_s1;
    s_next.int_d = s_reg.int_s2;

    // bus decode; one wait state, ack drops after one cycle
    rd = wb_cyc_i && wb_stb_i && !s_reg.ack && !wb_we_i;
    wr = wb_cyc_i && wb_stb_i && !s_reg.ack && wb_we_i;
    s_next.ack = wb_cyc_i && wb_stb_i && !s_reg.ack;
    tab_hit = (wb_adr_i >= ramp_pkg::ADR_TAB_BASE) && (wb_adr_i < ramp_pkg::ADR_TAB_END);
    toff = wb_adr_i - ramp_pkg::ADR_TAB_BASE;
    tidx = toff[8:4];
    fld = wb_adr_i[3:2];

    // read mux; unmapped reads return zero
    if (rd) begin
      s_next.rdat = '0;
      if (tab_hit) begin
        s_next.rdat = s_reg.tab[tidx][fld];
      end else begin
        case (wb_adr_i)
          ramp_pkg::ADR_CTRL: s_next.rdat = s_reg.ctrl;
          ramp_pkg::ADR_STATUS: s_next.rdat = {27'h000_0000, s_reg.run_s2, s_reg.dir,
                                               freq_changing_flag_o, s_reg.done, s_reg.active};
          ramp_pkg::ADR_IRQ_STAT: s_next.rdat = {29'h0000_0000, s_reg.irq_st};
          ramp_pkg::ADR_IRQ_EN: s_next.rdat = {29'h0000_0000, s_reg.irq_en};
          ramp_pkg::ADR_MON_FREQ: s_next.rdat = {15'h0000, s_reg.freq};
          ramp_pkg::ADR_MON_COUNT: s_next.rdat = {5'h00, s_reg.pcnt};
          ramp_pkg::ADR_MON_STEP: s_next.rdat = {27'h000_0000, s_reg.step};
          default: s_next.rdat = '0;
        endcase
      end
    end

    // control and table writes land in the software copy only; the run copy is taken at start
    if (wr) begin
      if (tab_hit) begin
        s_next.tab[tidx][fld] = merge(s_reg.tab[tidx][fld], wb_dat_i, wb_sel_i);
      end else begin
        case (wb_adr_i)
          ramp_pkg::ADR_CTRL: s_next.ctrl = merge(s_reg.ctrl, wb_dat_i, wb_sel_i);
          ramp_pkg::ADR_IRQ_CLR: clr = wb_sel_i[0] ? wb_dat_i[2:0] : 3'b000;
          ramp_pkg::ADR_IRQ_EN: s_next.irq_en = wb_sel_i[0] ? wb_dat_i[2:0] : s_reg.irq_en;
          default: ;
        endcase
      end
    end

    // initialization only while run is low
    if (s_reg.ini_s2 && !s_reg.run_s2) begin
      s_next.ctrl = ramp_pkg::CTRL_RST;
      for (int i = 0; i < ramp_pkg::STEPS; i++) begin
        s_next.tab[i] = {ramp_pkg::OPT_RST, ramp_pkg::PRESET_RST,
                         ramp_pkg::TIME_RST, ramp_pkg::FREQ_RST};
      end
    end

    // ramp tick, free running so the rate stays constant
    tick = (s_reg.tick_cnt == TICK_CYCLES - 32'h0000_0001);
    s_next.tick_cnt = tick ? 32'h0000_0000 : s_reg.tick_cnt + 32'h0000_0001;

    // where the frequency is heading right now
    if (s_reg.st == ramp_pkg::ST_TURN) begin
      rt = mn;
    end else if (s_reg.after && s_reg.pcnt < s_reg.preset) begin
      rt = s_reg.freq; // hold the previous frequency first
    end else begin
      rt = s_reg.tgt;
    end

    // sequencer
    case (s_reg.st)
      ramp_pkg::ST_IDLE: ;
      ramp_pkg::ST_RUN: begin
        if (nco_fall) begin
          s_next.pcnt = s_reg.pcnt + 27'h000_0001;
        end
        // before mode stops at the preset even mid-ramp; after mode finishes its ramp first
        if (s_reg.pcnt >= s_reg.preset && (s_reg.freq == s_reg.tgt || !s_reg.after)) begin
          s_next = load_step(s_next, s_reg.next);
        end
      end
      ramp_pkg::ST_TURN: begin
        if (s_reg.freq == mn) begin
          s_next.dir = s_reg.sdir;
          s_next.st = ramp_pkg::ST_RUN;
          s_next.rate = absdiff(s_reg.tgt, mn);
          s_next.acc = '0;
        end
      end
      default: s_next.st = ramp_pkg::ST_IDLE;
    endcase

    // ramp engine: bresenham over ms ticks, one unit per cycle at most
    if (s_reg.active && s_reg.freq != rt && s_next.st == s_reg.st) begin
      accn = s_reg.acc + (tick ? {15'h0000, s_reg.rate} : 32'h0000_0000);
      if (accn >= {18'h0_0000, s_reg.tms}) begin
        accn = accn - {18'h0_0000, s_reg.tms};
        s_next.freq = (rt > s_reg.freq) ? s_reg.freq + 17'h0_0001 : s_reg.freq - 17'h0_0001;
      end
      s_next.acc = accn;
    end

    // interrupt input jumps to the interrupt step
    if (s_reg.active && s_reg.int_s2 && !s_reg.int_d) begin
      s_next = load_step(s_next, s_reg.ctrl_run[ramp_pkg::CTRL_INT_LO +: 5]);
      ev[ramp_pkg::IRQ_JUMP] = 1'b1;
    end

    // run fall stops at once; run rise restarts from the beginning
    if (!s_reg.run_s2 && s_reg.run_d && s_reg.active) begin
      s_next.active = 1'b0;
      s_next.st = ramp_pkg::ST_IDLE;
      ev[ramp_pkg::IRQ_STOP] = 1'b1;
    end else if (s_reg.run_s2 && !s_reg.run_d) begin
      s_next.ctrl_run = s_reg.ctrl;
      s_next.tab_run = s_reg.tab;
      s_next.active = 1'b1;
      s_next.done = 1'b0;
      s_next.dir = 1'b0;
      s_next.freq = min_units(s_reg.ctrl);
      s_next.pcnt = '0;
      s_next = load_step(s_next, s_reg.ctrl[ramp_pkg::CTRL_START_LO +: 5]);
    end

    // done event when the sequence ends by itself
    ev[ramp_pkg::IRQ_DONE] = s_next.done && !s_reg.done;

    // sticky status; a new event beats a clear in the same cycle
    s_next.irq_st = (s_reg.irq_st & ~clr) | ev;

    // registered motor outputs
    s_next.pa = s_reg.active && nco_pulse &&
                (rev != ramp_pkg::REV_DUAL || !s_reg.dir);
    s_next.pb = s_reg.active && nco_pulse &&
                rev == ramp_pkg::REV_DUAL && s_reg.dir;
    s_next.dout = rev == ramp_pkg::REV_SINGLE && s_reg.dir;

    if (rst_i) begin
      s_next = '0;
      s_next.ctrl = ramp_pkg::CTRL_RST;
      s_next.st = ramp_pkg::ST_IDLE;
      for (int i = 0; i < ramp_pkg::STEPS; i++) begin
        s_next.tab[i] = {ramp_pkg::OPT_RST, ramp_pkg::PRESET_RST,
                         ramp_pkg::TIME_RST, ramp_pkg::FREQ_RST};
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  // ==========================================================
  // outputs
  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.rdat;
  assign pulse_out_a_o = s_reg.pa;
  assign pulse_out_b_o = s_reg.pb;
  assign direction_out_wide_o = s_reg.dout;
  assign direction_out_narrow_o = s_reg.dout;
  assign output_active_flag_o = s_reg.active;
  assign output_done_flag_o = s_reg.done;
  // high only while heading away from the current frequency
  assign freq_changing_flag_o = s_reg.active && (s_reg.st == ramp_pkg::ST_TURN ||
                                (s_reg.freq != s_reg.tgt &&
                                 !(s_reg.after && s_reg.pcnt < s_reg.preset)));
  assign irq_o = |(s_reg.irq_st & s_reg.irq_en);

endmodule

// [hdl/ramp_pkg.sv]
// ramp pulse generator: shared constants, register map and types
// assumes a single 25 MHz system clock and a classic wishbone master
//
// Overview of operation
// - a rising run input starts pulses on the primary output using latched settings
// - the output-active flag stays high for the whole time pulses are generated
// - the frequency-changing flag is high only while frequency rises or falls
// - frequency moves from its start value to the step target over the change time
// - at the preset pulse count of a step whose next step is 0 the output stops, active clears and done sets
// - a falling run input stops the pulse output at once
// - a new run rise clears the pulse counter and restarts from the start step
// - settings are captured at start; later writes act only at the next start
// - the initialization request is ignored while run is high
// - single-pulse reversible mode drives pulses plus a separate direction level
// - dual-pulse mode puts forward pulses on output a, reverse on output b
// - direction only reverses once frequency is at its minimum, 200 Hz in mode 1
// - mode 0 spans 1 Hz to 10 kHz by 1 Hz, mode 1 200 Hz to 100 kHz by 10 Hz
// - start loads the table entry chosen by the start step number
// - a rising interrupt input abandons the step and jumps to the interrupt step
package ramp_pkg;

  // ==========================================================
  // clock and timing
  localparam logic [31:0] CLK_HZ = 32'h017D_7840;
  localparam logic [31:0] TICK_MS = 32'h0000_0001;
  localparam logic [31:0] TICK_CYC = CLK_HZ * TICK_MS / 32'h0000_03E8;
  localparam logic [24:0] NCO_HALF = 25'(CLK_HZ >> 1);

  // ==========================================================
  // register map (byte addresses)
  localparam logic [11:0] ADR_CTRL = 12'h000;
  localparam logic [11:0] ADR_STATUS = 12'h004;
  localparam logic [11:0] ADR_IRQ_STAT = 12'h008;
  localparam logic [11:0] ADR_IRQ_CLR = 12'h00C;
  localparam logic [11:0] ADR_IRQ_EN = 12'h010;
  localparam logic [11:0] ADR_MON_FREQ = 12'h014;
  localparam logic [11:0] ADR_MON_COUNT = 12'h018;
  localparam logic [11:0] ADR_MON_STEP = 12'h01C;
  localparam logic [11:0] ADR_TAB_BASE = 12'h100;
  localparam logic [11:0] ADR_TAB_END = 12'h220;
  localparam int STEPS = 18;

  // table entry word index
  localparam logic [1:0] F_FREQ = 2'h0;
  localparam logic [1:0] F_TIME = 2'h1;
  localparam logic [1:0] F_PRESET = 2'h2;
  localparam logic [1:0] F_OPT = 2'h3;

  // control word fields
  localparam int CTRL_MODE = 0;
  localparam int CTRL_REV_LO = 1;
  localparam int CTRL_START_LO = 8;
  localparam int CTRL_INT_LO = 16;
  // step option fields
  localparam int OPT_DIR = 0;
  localparam int OPT_AFTER = 1;
  localparam int OPT_NEXT_LO = 8;
  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_STOP = 1;
  localparam int IRQ_JUMP = 2;

  // ==========================================================
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0001_0100;
  localparam logic [31:0] FREQ_RST = 32'h0000_0064;
  localparam logic [31:0] TIME_RST = 32'h0000_0064;
  localparam logic [31:0] PRESET_RST = 32'h0098_9680;
  localparam logic [31:0] OPT_RST = 32'h0000_0100;

  // frequency range per mode, in units of the mode's step
  localparam logic [16:0] MIN_LO = 17'h0_0001;
  localparam logic [16:0] MIN_HI = 17'h0_0014;
  localparam logic [16:0] SCALE_HI = 17'h0_000A;

  typedef enum logic [1:0] {
    REV_OFF = 2'b00,
    REV_SINGLE = 2'b01,
    REV_DUAL = 2'b10
  } rev_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_TURN = 2'b10
  } fsm_t;

endpackage

// [hdl/pulse_nco.sv]
// pulse_nco: divides the system clock into a square pulse train
// assumes hz_i changes only between clock edges of the same domain
module pulse_nco (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic en_i,
  input wire logic [16:0] hz_i,
  // pulse
  output logic pulse_o,
  output logic fall_o
);

  typedef struct packed {
    logic [24:0] acc;
    logic lvl;
    logic fall;
  } nco_t;

  nco_t s_reg;
  nco_t s_next;

  // ==========================================================
  // phase accumulator, toggles every half period
  always_comb begin
    logic [24:0] sum;
    sum = s_reg.acc + 25'(hz_i);
    s_next = s_reg;
    s_next.fall = 1'b0;
    if (rst_i || !en_i) begin
      s_next.acc = '0; // stop drops the level at once
      s_next.lvl = 1'b0;
    end else if (sum >= ramp_pkg::NCO_HALF) begin
      s_next.acc = sum - ramp_pkg::NCO_HALF;
      s_next.lvl = !s_reg.lvl;
      s_next.fall = s_reg.lvl; // a full pulse has ended
    end else begin
      s_next.acc = sum;
    end
  end

  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  assign pulse_o = s_reg.lvl;
  assign fall_o = s_reg.fall;

endmodule

// [verif/ramp_pulse_properties.sv]
// checker for the ramp pulse channel, watching its top-level ports only
// assumes one clock domain and the synchronous active-high reset
module ramp_pulse_properties (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // pins
  input wire logic run_input_pin_i,
  input wire logic pulse_out_a_o,
  input wire logic pulse_out_b_o,
  input wire logic direction_out_wide_o,
  input wire logic direction_out_narrow_o,
  input wire logic output_active_flag_o,
  input wire logic output_done_flag_o,
  input wire logic freq_changing_flag_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // clocking
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reset_quiet:
    assert property ($fell(rst_i) |-> !(pulse_out_a_o | pulse_out_b_o | direction_out_wide_o
      | direction_out_narrow_o | output_active_flag_o | output_done_flag_o | freq_changing_flag_o))
    else $error("outputs not idle after reset");
  a_ack_follows:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack one cycle on");
  a_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_start_latency:
    assert property ($rose(run_input_pin_i) && !output_active_flag_o |-> ##[2:4] output_active_flag_o)
    else $error("run rise did not start output");
  a_active_cause:
    assert property ($rose(output_active_flag_o) |-> $past(run_input_pin_i, 2)) else $error("start without run");
  a_pulse_active:
    assert property (!output_active_flag_o && !$past(output_active_flag_o) |-> !pulse_out_a_o && !pulse_out_b_o)
    else $error("pulse while not active");
  a_run_fall_stop:
    assert property ($fell(run_input_pin_i) |-> ##[1:4] !output_active_flag_o) else $error("run fall ignored");
  a_done_entry:
    assert property ($rose(output_done_flag_o) |-> $fell(output_active_flag_o)) else $error("done without stop");
  a_changing_active:
    assert property (freq_changing_flag_o |-> output_active_flag_o) else $error("changing while idle");
  a_dir_pair:
    assert property (direction_out_wide_o == direction_out_narrow_o) else $error("direction outputs differ");
  a_dual_dir_quiet:
    assert property (pulse_out_b_o |-> !direction_out_wide_o) else $error("direction used in dual mode");
endmodule

bind ramp_pulse_channel_one ramp_pulse_properties chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .run_input_pin_i(run_input_pin_i), .pulse_out_a_o(pulse_out_a_o),
  .pulse_out_b_o(pulse_out_b_o), .direction_out_wide_o(direction_out_wide_o),
  .direction_out_narrow_o(direction_out_narrow_o), .output_active_flag_o(output_active_flag_o),
  .output_done_flag_o(output_done_flag_o), .freq_changing_flag_o(freq_changing_flag_o));

// [verif/motor_driver_model.sv]
// motor driver model: counts steps from the pulse and direction lines
// assumes pulses are far slower than clk_i, so sampling on it is enough
module motor_driver_model (
  // system
  input wire logic clk_i,
  // motor pins
  input wire logic pulse_a_i,
  input wire logic pulse_b_i,
  input wire logic dir_i,
  // step counts
  output logic [31:0] fwd_o,
  output logic [31:0] rev_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic a_q = 1'b0;
  logic b_q = 1'b0;
  initial begin
    fwd_o = '0;
    rev_o = '0;
  end
  // a rise on a is one step in the sense of dir; b only ever steps reverse
  always @(posedge clk_i) begin
    a_q <= pulse_a_i;
    b_q <= pulse_b_i;
    if (pulse_a_i && !a_q && dir_i) rev_o <= rev_o + 1;
    if (pulse_a_i && !a_q && !dir_i) fwd_o <= fwd_o + 1;
    if (pulse_b_i && !b_q) rev_o <= rev_o + 1;
  end
endmodule

// [verif/ramp_pulse_channel_one_tb.sv]
// testbench for the ramp pulse channel: wishbone tasks and ramp scenarios
// assumes the ramp tick is cut to 25 cycles and mode 1 so pulses come fast
module ramp_pulse_channel_one_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic run = 1'b0, init = 1'b0, intr = 1'b0, ack, pa, pb, dw, dn, act, done, chg, irq;
  logic [11:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] wdat = '0, rdat, dat_o, fwd, rev, snap, f0, r0;
  int errors = 0, tests_run = 0, cycles = 0;

  ramp_pulse_channel_one #(.TICK_CYCLES(32'h0000_0019)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .run_input_pin_i(run), .init_request_input_i(init), .step_interrupt_i(intr),
    .pulse_out_a_o(pa), .pulse_out_b_o(pb), .direction_out_wide_o(dw), .direction_out_narrow_o(dn),
    .output_active_flag_o(act), .output_done_flag_o(done), .freq_changing_flag_o(chg), .irq_o(irq));
  motor_driver_model drv (.clk_i(clk_i), .pulse_a_i(pa), .pulse_b_i(pb), .dir_i(dw), .fwd_o(fwd), .rev_o(rev));

  always #20 clk_i = ~clk_i;
  // hang guard: the whole sequence needs under this many cycles, but not by a wide margin
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      errors++;
      stop_test();
    end
  end

  // ==========================================================
  // tasks
  task automatic stop_test();
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // classic cycle: hold everything until ack is sampled, then release
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a);
    xfer(a, 1'b0, 32'h0000_0000);
  endtask
  function automatic logic [11:0] tab(input int s, input int w);
    return ramp_pkg::ADR_TAB_BASE + 12'((s - 1) * 16 + w * 4);
  endfunction
  // one table entry at full speed, with the shortest change time
  task automatic setstep(input int s, input logic [31:0] p, input logic [31:0] o);
    wr(tab(s, 0), 32'h0000_2710);
    wr(tab(s, 1), 32'h0000_0001);
    wr(tab(s, 2), p);
    wr(tab(s, 3), o);
  endtask
  task automatic start();
    f0 = fwd;
    r0 = rev;
    @(posedge clk_i);
    run <= 1'b1;
    while (act !== 1'b1) @(posedge clk_i);
  endtask
  task automatic halt();
    @(posedge clk_i);
    run <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask

  // ==========================================================
  // sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'({pa, pb, dw, dn, act, done, chg, irq}), 32'h0000_0000);
    rd(ramp_pkg::ADR_CTRL);
    chk(rdat, ramp_pkg::CTRL_RST);
    rd(tab(1, 2));
    chk(rdat, ramp_pkg::PRESET_RST);
    wr(12'h030, 32'h0000_FFFF);
    rd(12'h030);
    chk(rdat, 32'h0000_0000);
    // plain run: ramp up, hold target, stop at the preset count
    wr(ramp_pkg::ADR_CTRL, 32'h0001_0101);
    setstep(1, 32'h0000_001E, 32'h0000_0000);
    start();
    while (chg !== 1'b1) @(posedge clk_i);
    while (chg !== 1'b0) @(posedge clk_i);
    rd(ramp_pkg::ADR_MON_FREQ);
    chk(rdat, 32'h0000_2710);
    while (done !== 1'b1) @(posedge clk_i);
    chk(fwd - f0, 32'h0000_001E);
    chk(32'(act), 32'h0000_0000);
    rd(ramp_pkg::ADR_IRQ_STAT);
    chk(rdat, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    wr(ramp_pkg::ADR_IRQ_EN, 32'h0000_0001);
    @(posedge clk_i);
    chk(32'(irq), 32'h0000_0001);
    wr(ramp_pkg::ADR_IRQ_CLR, 32'h0000_0001);
    @(posedge clk_i);
    chk(32'(irq), 32'h0000_0000);
    halt();
    // late write must wait for the next start; run fall stops at once
    setstep(1, 32'h0000_03E8, 32'h0000_0000);
    start();
    repeat (1000) @(posedge clk_i);
    wr(tab(1, 2), 32'h0000_0005);
    repeat (1000) @(posedge clk_i);
    chk(32'(act), 32'h0000_0001);
    halt();
    chk(32'(act), 32'h0000_0000);
    snap = fwd;
    repeat (600) @(posedge clk_i);
    chk(fwd, snap);
    start();
    while (done !== 1'b1) @(posedge clk_i);
    chk(fwd - f0, 32'h0000_0005);
    rd(ramp_pkg::ADR_IRQ_STAT);
    chk(rdat, 32'h0000_0003);
    wr(ramp_pkg::ADR_IRQ_CLR, 32'h0000_0003);
    halt();
    // reversible modes: step 1 forward, then step 2 reverse, then end
    for (int m = 1; m < 3; m++) begin
      wr(ramp_pkg::ADR_CTRL, 32'h0001_0101 | 32'(m << 1));
      setstep(1, 32'h0000_000A, 32'h0000_0200);
      setstep(2, 32'h0000_000A, 32'h0000_0001);
      start();
      while (done !== 1'b1) @(posedge clk_i);
      chk(rev - r0, 32'h0000_000A);
      chk(32'(fwd - f0 >= 32'h0000_000A), 32'h0000_0001);
      halt();
    end
    // start at step 2, jump to step 3 on the interrupt input
    wr(ramp_pkg::ADR_CTRL, 32'h0003_0201);
    setstep(2, 32'h0000_03E8, 32'h0000_0000);
    setstep(3, 32'h0000_0005, 32'h0000_0000);
    start();
    repeat (1000) @(posedge clk_i);
    rd(ramp_pkg::ADR_MON_STEP);
    chk(rdat, 32'h0000_0002);
    while (pa !== 1'b1) @(posedge clk_i);
    while (pa !== 1'b0) @(posedge clk_i);
    snap = fwd;
    intr <= 1'b1;
    repeat (4) @(posedge clk_i);
    intr <= 1'b0;
    while (done !== 1'b1) @(posedge clk_i);
    chk(fwd - snap, 32'h0000_0005);
    rd(ramp_pkg::ADR_MON_STEP);
    chk(rdat, 32'h0000_0003);
    // init is ignored with run high and acts once run has dropped
    init <= 1'b1;
    repeat (4) @(posedge clk_i);
    init <= 1'b0;
    rd(ramp_pkg::ADR_CTRL);
    chk(rdat, 32'h0003_0201);
    halt();
    init <= 1'b1;
    repeat (4) @(posedge clk_i);
    init <= 1'b0;
    rd(ramp_pkg::ADR_CTRL);
    chk(rdat, ramp_pkg::CTRL_RST);
    rd(tab(3, 2));
    chk(rdat, ramp_pkg::PRESET_RST);
    // mode 0 with a target below its range sits steady at the 1 Hz floor
    wr(tab(1, 0), 32'h0000_0000);
    start();
    rd(ramp_pkg::ADR_MON_FREQ);
    chk(rdat, 32'h0000_0001);
    chk(32'(chg), 32'h0000_0000);
    stop_test();
  end
endmodule
